// File: verilog/fetch_cfg.svh
`ifndef FETCH_CFG_SVH
`define FETCH_CFG_SVH
`define PC_W         21
`define PC_STEP      21'h000002
`define PC_RESET     21'h000000
`define SECOND_TAG   4'hF
`define PHASE_RESET  4'h1
`define NOP_WORD     16'hF000
`define OP_GOTO      8'hEF
`define OP_CALL      8'hEC
`define OP_MOVE_FILE_TO_FILE     4'hC
`define OP_LFSR      8'hEE
`define OP_BRA       5'h1A
`define OP_RETURN_WITH_LITERAL     8'h0C
`define OP_ADD_WORKING_TO_FILE_PCL 16'h26F9
`define OP_TBLRD     16'h0008
`define OP_MOVLW     8'h0E
`endif

// File: verilog/fetch_pkg.sv
`default_nettype none
package fetch_pkg;
	typedef enum logic [3:0] {
		PH_ONE   = 4'h1,
		PH_TWO   = 4'h2,
		PH_THREE = 4'h4,
		PH_FOUR  = 4'h8
	} phase_t;
	typedef struct packed {
		logic [20:0] addr;
		logic        rd;
	} pmem_req_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} dmem_req_t;
endpackage
`default_nettype wire

// File: verilog/phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "fetch_cfg.svh"
module phase_gen (
	input  wire logic             clk,
	input  wire logic             rst_n,
	output fetch_pkg::phase_t     phase
);
	fetch_pkg::phase_t phase_reg;
	assign phase = phase_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg <= fetch_pkg::PH_ONE;
		end else begin
			case (phase_reg)
				fetch_pkg::PH_ONE:   phase_reg <= fetch_pkg::PH_TWO;
				fetch_pkg::PH_TWO:   phase_reg <= fetch_pkg::PH_THREE;
				fetch_pkg::PH_THREE: phase_reg <= fetch_pkg::PH_FOUR;
				fetch_pkg::PH_FOUR:  phase_reg <= fetch_pkg::PH_ONE;
				default:             phase_reg <= fetch_pkg::PH_ONE;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: verilog/instruction_fetch_pipeline.sv
`timescale 1ns/1ps
`default_nettype none
`include "fetch_cfg.svh"
module instruction_fetch_pipeline (
	input  wire logic                REF_CLK,
	input  wire logic                RST_N,
	input  wire logic [15:0]         PMEM_RDATA,
	input  wire logic [7:0]          DMEM_RDATA,
	input  wire logic [20:0]         RETURN_ADDR,
	input  wire logic [20:0]         TABLE_POINTER,
	output fetch_pkg::pmem_req_t     PMEM_REQ,
	output fetch_pkg::dmem_req_t     DMEM_REQ,
	output fetch_pkg::phase_t        PHASE,
	output logic [20:0]              PROGRAM_COUNTER,
	output logic [15:0]              INSTRUCTION_REGISTER,
	output logic [7:0]               WORKING_REGISTER,
	output logic [7:0]               TABLE_LATCH,
	output logic                     CALL_PUSH,
	output logic                     RETURN_POP
);
	fetch_pkg::phase_t    phase;
	fetch_pkg::pmem_req_t pmem_reg;
	fetch_pkg::dmem_req_t dmem_reg;
	fetch_pkg::phase_t    phase_reg;
	logic [20:0] pc_reg;
	logic [20:0] pc_next;
	logic [15:0] fetch_reg;
	logic [15:0] ir_reg;
	logic [15:0] first_reg;
	logic        second_reg;
	logic        flush_reg;
	logic        tbl_reg;
	logic [7:0]  w_reg;
	logic [7:0]  tlat_reg;
	logic        push_reg;
	logic        pop_reg;
	logic        chg;
	logic        two_word;
	logic [20:0] target;
	logic [7:0]  pcl_sum;
	logic        tbl_go;
	logic        boot_reg;

	phase_gen u_phase (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.phase (phase)
	);

	// Decode the word now in the instruction register; flush forces a no-operation.
	always_comb begin
		chg = 1'b0;
		two_word = 1'b0;
		target = pc_reg;
		pcl_sum = pc_reg[7:0] + w_reg;
		tbl_go = 1'b0;
		if (!flush_reg && !second_reg) begin
			if (ir_reg[15:8] == `OP_GOTO || ir_reg[15:8] == `OP_CALL ||
			    ir_reg[15:12] == `OP_MOVE_FILE_TO_FILE || ir_reg[15:8] == `OP_LFSR) begin
				two_word = 1'b1;
			end
			if (ir_reg[15:11] == `OP_BRA) begin
				chg = 1'b1;
				target = pc_reg + {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
			end
			if (ir_reg[15:8] == `OP_RETURN_WITH_LITERAL) begin
				chg = 1'b1;
				target = {RETURN_ADDR[20:1], 1'b0};
			end
			if (ir_reg == `OP_ADD_WORKING_TO_FILE_PCL) begin
				chg = 1'b1;
				target = {pc_reg[20:8], pcl_sum[7:1], 1'b0};
			end
			// word address load
			// The second word already sits in the prefetch latch, so the jump costs only two cycles.
			if (ir_reg[15:8] == `OP_GOTO || ir_reg[15:8] == `OP_CALL) begin
				chg = 1'b1;
				target = {fetch_reg[11:0], ir_reg[7:0], 1'b0};
			end
			if (ir_reg == `OP_TBLRD) begin
				tbl_go = 1'b1;
			end
		end
		// Out of reset there is no valid prefetch, so the first fetch must use the reset address.
		if (boot_reg) begin
			chg = 1'b1;
		end
	end

	assign pc_next = chg ? target : pc_reg + `PC_STEP;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pc_reg <= `PC_RESET;
			boot_reg <= 1'b1;
		end else if (phase == fetch_pkg::PH_ONE) begin
			boot_reg <= 1'b0;
			// A table read borrows the next fetch slot, so the counter waits one cycle.
			if (!tbl_go) begin
				pc_reg <= {pc_next[20:1], 1'b0};
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pmem_reg <= '0;
			fetch_reg <= `NOP_WORD;
			tbl_reg <= 1'b0;
			tlat_reg <= 8'h00;
		end else begin
			pmem_reg.rd <= (phase == fetch_pkg::PH_THREE);
			if (phase == fetch_pkg::PH_TWO) begin
				pmem_reg.addr <= pc_reg;
			end
			if (phase == fetch_pkg::PH_FOUR) begin
				fetch_reg <= PMEM_RDATA;
			end
			if (phase == fetch_pkg::PH_ONE && tbl_go) begin
				tbl_reg <= 1'b1;
			end else if (phase == fetch_pkg::PH_FOUR) begin
				tbl_reg <= 1'b0;
			end
			// The memory is word wide; the pointer's bit zero only picks the byte below.
			if (tbl_reg && phase == fetch_pkg::PH_TWO) begin
				pmem_reg.addr <= {TABLE_POINTER[20:1], 1'b0};
			end
			if (tbl_reg && phase == fetch_pkg::PH_FOUR) begin
				tlat_reg <= TABLE_POINTER[0] ? PMEM_RDATA[15:8] : PMEM_RDATA[7:0];
				fetch_reg <= fetch_reg;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ir_reg <= `NOP_WORD;
			first_reg <= `NOP_WORD;
			second_reg <= 1'b0;
			flush_reg <= 1'b1;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
		end else begin
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			if (phase == fetch_pkg::PH_ONE) begin
				// The word held back by a table read must not execute twice.
				ir_reg <= tbl_go ? `NOP_WORD : fetch_reg;
				flush_reg <= chg;
				second_reg <= two_word;
				if (two_word) begin
					first_reg <= ir_reg;
				end
				push_reg <= second_reg && first_reg[15:8] == `OP_CALL;
				pop_reg <= !flush_reg && !second_reg && ir_reg[15:8] == `OP_RETURN_WITH_LITERAL;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			dmem_reg <= '0;
			w_reg <= 8'h00;
		end else begin
			dmem_reg.rd <= 1'b0;
			dmem_reg.wr <= 1'b0;
			// The source is read as the second word enters, so the write can follow in phase four.
			if (phase == fetch_pkg::PH_ONE && two_word && ir_reg[15:12] == `OP_MOVE_FILE_TO_FILE) begin
				dmem_reg.addr <= ir_reg[11:0];
				dmem_reg.rd <= 1'b1;
			end
			if (phase == fetch_pkg::PH_TWO && dmem_reg.rd) begin
				dmem_reg.wdata <= DMEM_RDATA;
			end
			if (phase == fetch_pkg::PH_THREE && second_reg && first_reg[15:12] == `OP_MOVE_FILE_TO_FILE) begin
				dmem_reg.addr <= ir_reg[11:0];
				dmem_reg.wr <= 1'b1;
			end
			if (phase == fetch_pkg::PH_FOUR && !flush_reg && !second_reg) begin
				if (ir_reg[15:8] == `OP_RETURN_WITH_LITERAL || ir_reg[15:8] == `OP_MOVLW) begin
					w_reg <= ir_reg[7:0];
				end
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			phase_reg <= fetch_pkg::PH_ONE;
		end else begin
			phase_reg <= phase;
		end
	end

	assign PMEM_REQ             = pmem_reg;
	assign DMEM_REQ             = dmem_reg;
	assign PHASE                = phase_reg;
	assign PROGRAM_COUNTER      = pc_reg;
	assign INSTRUCTION_REGISTER = ir_reg;
	assign WORKING_REGISTER     = w_reg;
	assign TABLE_LATCH          = tlat_reg;
	assign CALL_PUSH            = push_reg;
	assign RETURN_POP           = pop_reg;
endmodule
`default_nettype wire

// File: dv/instruction_fetch_pipeline_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_checker (
	input wire logic                 REF_CLK,
	input wire logic                 RST_N,
	input wire fetch_pkg::pmem_req_t PMEM_REQ,
	input wire fetch_pkg::dmem_req_t DMEM_REQ,
	input wire fetch_pkg::phase_t    PHASE,
	input wire logic [20:0]          PROGRAM_COUNTER,
	input wire logic                 CALL_PUSH,
	input wire logic                 RETURN_POP
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	a_phase_onehot: assert property ($onehot(PHASE)) else $error("phase not one-hot");
	a_phase_wrap: assert property (PHASE == fetch_pkg::PH_FOUR |=> PHASE == fetch_pkg::PH_ONE)
		else $error("phase four not followed by one");
	a_pc_even: assert property (!PROGRAM_COUNTER[0]) else $error("odd counter");
	a_pc_hold: assert property ($changed(PROGRAM_COUNTER) |=> $stable(PROGRAM_COUNTER)[*3])
		else $error("counter moved twice in a cycle");
	a_fetch_rate: assert property (PMEM_REQ.rd |=> (!PMEM_REQ.rd)[*3] ##1 PMEM_REQ.rd)
		else $error("fetch not every four clocks");
	a_addr_even: assert property (PMEM_REQ.rd |-> !PMEM_REQ.addr[0]) else $error("odd fetch address");
	a_addr_hold: assert property (PMEM_REQ.rd |-> $stable(PMEM_REQ.addr)) else $error("address moved");
	a_write_once: assert property (DMEM_REQ.wr |=> (!DMEM_REQ.wr)[*3])
		else $error("second write in a cycle");
	a_pop_pulse: assert property (RETURN_POP |=> !RETURN_POP) else $error("return pulse too long");
	c_fetch: cover property (PMEM_REQ.rd);
	c_write: cover property (DMEM_REQ.wr);
	c_push: cover property (CALL_PUSH);
	c_pop: cover property (RETURN_POP);
endmodule
bind instruction_fetch_pipeline fetch_checker chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PMEM_REQ(PMEM_REQ),
	.DMEM_REQ(DMEM_REQ), .PHASE(PHASE), .PROGRAM_COUNTER(PROGRAM_COUNTER), .CALL_PUSH(CALL_PUSH), .RETURN_POP(RETURN_POP));
`default_nettype wire

// File: dv/memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module memory_model (
	input wire logic                 clk,
	input wire fetch_pkg::pmem_req_t pmem_req,
	input wire fetch_pkg::dmem_req_t dmem_req,
	output logic [15:0]              pmem_rdata,
	output logic [7:0]               dmem_rdata
);
	logic [15:0] pmem [0:255];
	logic [7:0]  dmem [0:4095];
	logic [15:0] plast_reg;
	logic [7:0]  dlast_reg;
	assign pmem_rdata = pmem_req.rd ? pmem[pmem_req.addr[8:1]] : ~plast_reg;
	assign dmem_rdata = dmem_req.rd ? dmem[dmem_req.addr] : ~dlast_reg;
	// Idle data toggles every cycle so a late sample never sees a stale word.
	always_ff @(posedge clk) begin
		plast_reg <= pmem_rdata;
		dlast_reg <= dmem_rdata;
	end
	// The bench preloads data bytes, so the array is not owned by an always_ff.
	always @(posedge clk) begin
		if (dmem_req.wr) begin
			dmem[dmem_req.addr] <= dmem_req.wdata;
		end
	end
endmodule
`default_nettype wire

// File: dv/instruction_fetch_pipeline_tb.sv
`timescale 1ns/1ps
`default_nettype none
module instruction_fetch_pipeline_tb;
	logic                 ref_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic [15:0]          pmem_rdata;
	logic [7:0]           dmem_rdata;
	fetch_pkg::pmem_req_t pmem_req;
	fetch_pkg::dmem_req_t dmem_req;
	logic [20:0]          pc;
	logic [15:0]          ir;
	logic [7:0]           w;
	logic [7:0]           tlat;
	logic                 push;
	logic [20:0]          ret_addr = 21'h000040;
	logic [20:0]          tbl_ptr = 21'h000031;
	logic                 bad_w = 1'b0;
	int                   error_cnt = 0;
	int                   checks = 0;
	int                   cyc = 0;
	instruction_fetch_pipeline dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .PMEM_RDATA(pmem_rdata),
		.DMEM_RDATA(dmem_rdata), .RETURN_ADDR(ret_addr), .TABLE_POINTER(tbl_ptr), .PMEM_REQ(pmem_req),
		.DMEM_REQ(dmem_req), .PHASE(), .PROGRAM_COUNTER(pc), .INSTRUCTION_REGISTER(ir), .WORKING_REGISTER(w),
		.TABLE_LATCH(tlat), .CALL_PUSH(push), .RETURN_POP());
	memory_model mem_u (.clk(ref_clk), .pmem_req(pmem_req), .dmem_req(dmem_req), .pmem_rdata(pmem_rdata),
		.dmem_rdata(dmem_rdata));
	task automatic check(string name, logic [20:0] seen, logic [20:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial forever #50 ref_clk = ~ref_clk;
	// Words that only a flushed prefetch or a wrong offset could put in the working register.
	always @(negedge ref_clk) begin
		cyc <= cyc + 1;
		if (w === 8'h77 || w === 8'h11 || w === 8'h22) begin
			bad_w <= 1'b1;
		end
		if (cyc == 2000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic t_first();
		for (int i = 0; i < 12 && w !== 8'h04; i++) @(negedge ref_clk);
		check("w", w, 21'h04);
		$display("first done");
	endtask
	task automatic t_call();
		for (int i = 0; i < 40 && push !== 1'b1; i++) @(negedge ref_clk);
		check("push", push, 21'h1);
		for (int i = 0; i < 20 && ir !== 16'h26F9; i++) @(negedge ref_clk);
		check("ir", ir, 21'h26F9);
		$display("call done");
	endtask
	task automatic t_jump();
		for (int i = 0; i < 40 && w !== 8'hA5; i++) @(negedge ref_clk);
		check("w", w, 21'hA5);
		$display("jump done");
	endtask
	task automatic t_table();
		for (int i = 0; i < 40 && tlat !== 8'hBE; i++) @(negedge ref_clk);
		check("tlat", tlat, 21'hBE);
		check("dmem", mem_u.dmem[12'h456], 21'h5A);
		check("w", w, 21'hA5);
		$display("table done");
	endtask
	task automatic t_branch();
		for (int i = 0; i < 16; i++) begin
			@(negedge ref_clk);
			check("pc", pc & ~21'h2, 21'h48);
		end
		check("bad_w", bad_w, 21'h0);
		$display("branch done");
	endtask
	initial begin
		mem_u.pmem[0] = 16'h0E04;
		mem_u.pmem[1] = 16'hEC08;
		mem_u.pmem[2] = 16'hF000;
		mem_u.pmem[3] = 16'h0E77;
		mem_u.pmem[8] = 16'h26F9;
		mem_u.pmem[9] = 16'h0C11;
		mem_u.pmem[10] = 16'h0C22;
		mem_u.pmem[11] = 16'h0CA5;
		mem_u.pmem[24] = 16'hBEEF;
		mem_u.pmem[32] = 16'hF123;
		mem_u.pmem[33] = 16'hC123;
		mem_u.pmem[34] = 16'hF456;
		mem_u.pmem[35] = 16'h0008;
		mem_u.pmem[36] = 16'hD7FF;
		mem_u.dmem[12'h123] = 8'h5A;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_first();
		t_call();
		t_jump();
		t_table();
		t_branch();
		end_sim();
	end
endmodule
`default_nettype wire
